// *** src/flash_sec_consts.svh ***
// constants for the flash security, protection and command front end
// assumes byte-wide registers at 16-bit cpu addresses
`ifndef FLASH_SEC_CONSTS_SVH
`define FLASH_SEC_CONSTS_SVH
`define ADR_DIV        16'h1820
`define ADR_OPT        16'h1821
`define ADR_CFG        16'h1823
`define ADR_PROT       16'h1824
`define ADR_STAT       16'h1825
`define ADR_CMD        16'h1826
`define ADR_IRQ_STAT   16'h1828
`define ADR_IRQ_CLR    16'h1829
`define ADR_IRQ_EN     16'h182A
`define ADR_REG_LO     16'h1800
`define ADR_REG_HI     16'h182B
`define ADR_FLASH_LO   16'h1000
`define ADR_KEY        16'hFFB0
`define ADR_KEY_HI     16'hFFB7
`define ADR_NV_PROTECTION_SETUP     16'hFFBD
`define ADR_NV_OPTION_SETUP      16'hFFBF
`define PAGE_MASK      16'hFE00
`define ARRAY_TOP      17'h1_0000
`define PROT_MIN       17'h0_0200
`define PROT_MAX_SEL   3'h6
`define CMD_BLANK      8'h05
`define CMD_PROG       8'h20
`define CMD_BURST      8'h25
`define CMD_PAGE_ERASE 8'h40
`define CMD_MASS_ERASE 8'h41
`define STAT_CBEF      7
`define STAT_CCF       6
`define STAT_PVIOL     5
`define STAT_ACCERR    4
`define STAT_BLANK     2
`define CFG_KEY_WRITE_ACCESS     5
`define OPT_KEY_UNLOCK_ENABLE      7
`define OPT_NORED      6
`define SEC_UNSECURED  2'h2
`define PROT_OPEN      7
`define PROT_DIS       6
`define DIV_LOADED     7
`define IRQ_DONE       0
`define IRQ_PVIOL      1
`define IRQ_ACCERR     2
`define IRQ_UNSEC      3
`define LD_LAST        4'hA
`define LD_KEY_FIRST   4'h2
`define ZERO8          8'h00
`define ONES8          8'hFF
`endif

// *** src/flash_sec_pkg.sv ***
// types for the flash security, protection and command front end
// assumes flash_sec_consts.svh is on the include path
package flash_sec_pkg;
   // command sequencer, gray coded along the usual path
   typedef enum logic [1:0] {
      SEQ_EMPTY = 2'h0,
      SEQ_ADDR  = 2'h1,
      SEQ_CMD   = 2'h3,
      SEQ_BUSY  = 2'h2
   } seq_state_t;

   // one registered command handed to the array engine
   typedef struct packed {
      logic [7:0]  code;
      logic [15:0] addr;
      logic [7:0]  data;
   } flash_cmd_t;
endpackage

// *** src/flash_sec_ctrl.sv ***
// flash security, block protection and command front end
// assumes a same-clock array engine and a same-clock cpu register port
`include "flash_sec_consts.svh"
module flash_sec_ctrl
   import flash_sec_pkg::*;
(
   input  wire logic        core_clk_i,
   input  wire logic        arst_n_i,
   input  wire logic [15:0] reg_addr_i,
   input  wire logic [7:0]  reg_wdata_i,
   input  wire logic        reg_wr_i,
   input  wire logic        reg_rd_i,
   output      logic [7:0]  reg_rdata_o,
   input  wire logic        bdm_access_i,
   input  wire logic        secure_code_i,
   output      logic [15:0] nv_addr_o,
   input  wire logic [7:0]  nv_data_i,
   output      logic        load_done_o,
   output      logic        op_start_o,
   output      flash_cmd_t  op_cmd_o,
   input  wire logic        op_done_i,
   input  wire logic        op_blank_i,
   output      logic        secure_o,
   output      logic        vector_redirect_disable_o,
   output      logic        irq_o
);

   // address of each nonvolatile byte fetched after reset
   function automatic logic [15:0] load_addr(input logic [3:0] step);
      if (step == 4'h0) begin
         load_addr = `ADR_NV_PROTECTION_SETUP;
      end else if (step == 4'h1) begin
         load_addr = `ADR_NV_OPTION_SETUP;
      end else begin
         load_addr = `ADR_KEY + {12'h000, step - `LD_KEY_FIRST};
      end
   endfunction

   // protected block at the top end, size field
   function automatic logic prot_hit(input logic [7:0]  prot,
                                     input logic [15:0] addr,
                                     input logic        whole);
      logic [2:0]  sel;
      logic [16:0] limit;
      sel   = (prot[5:3] > `PROT_MAX_SEL) ? `PROT_MAX_SEL : prot[5:3];
      limit = `ARRAY_TOP - (`PROT_MIN << sel);
      if (!prot[`PROT_OPEN]) begin
         prot_hit = 1'b1;
      end else if (prot[`PROT_DIS]) begin
         prot_hit = 1'b0;
      end else begin
         prot_hit = whole | ({1'b0, addr} >= limit);
      end
   endfunction

   logic [3:0]  ld_cnt_r;
   logic        loaded_r;
   logic [15:0] nv_addr_r;
   logic [7:0]  prot_r;
   logic [7:0]  opt_r;
   logic [7:0]  key_r [8];
   logic [7:0]  key_in_r [8];
   logic [7:0]  key_mask_r;
   logic [7:0]  key_eq;
   logic        unlocked_r;
   logic        mass_erased_r;
   logic [7:0]  div_r;
   logic        key_write_access_r;
   seq_state_t  seq_r;
   flash_cmd_t  buf_r;
   logic        start_r;
   logic        pviol_r;
   logic        accerr_r;
   logic        blank_r;
   logic [3:0]  irq_stat_r;
   logic [3:0]  irq_en_r;
   logic [7:0]  rdata_r;

   logic        in_regs;
   logic        in_key;
   logic        key_ok;
   logic        key_wr;
   logic        flash_wr;
   logic        ctrl_wr;
   logic        stat_wr;
   logic        cmd_wr;
   logic        cmd_legal;
   logic        is_mod;
   logic        done_ev;
   logic        pviol_set;
   logic        accerr_set;
   logic        unlock_set;
   logic [7:0]  stat_view;
   logic [7:0]  opt_view;

   // reset load of working copies, one byte per cycle
   always_ff @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         ld_cnt_r  <= 4'h0;
         nv_addr_r <= `ADR_NV_PROTECTION_SETUP;
         loaded_r  <= 1'b0;
      end else if (!loaded_r) begin
         if (ld_cnt_r == `LD_LAST) begin
            loaded_r <= 1'b1;
         end else begin
            ld_cnt_r  <= ld_cnt_r + 4'h1;
            nv_addr_r <= load_addr(ld_cnt_r + 4'h1);
         end
      end
   end

   // stored key captured from nonvolatile memory
   generate
      for (genvar i = 0; i < 8; i++) begin : g_key
         always_ff @(posedge core_clk_i or negedge arst_n_i) begin
            if (!arst_n_i) begin
               key_r[i] <= `ZERO8;
            end else if (!loaded_r && ld_cnt_r == 4'(i) + `LD_KEY_FIRST + 4'h1) begin
               key_r[i] <= nv_data_i;
            end
         end
         assign key_eq[i] = (key_r[i] == key_in_r[i]);
      end
   endgenerate

   // protection byte taken from the array; software may rewrite it
   always_ff @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         prot_r <= `ZERO8;
         opt_r  <= `ZERO8;
      end else if (!loaded_r && ld_cnt_r == 4'h1) begin
         prot_r <= nv_data_i;
      end else if (!loaded_r && ld_cnt_r == 4'h2) begin
         opt_r <= nv_data_i;
      end else if (reg_wr_i && reg_addr_i == `ADR_PROT && seq_r == SEQ_EMPTY) begin
         prot_r <= {reg_wdata_i[7:3], 3'h0};
      end
   end

   assign in_regs = (reg_addr_i >= `ADR_REG_LO) && (reg_addr_i <= `ADR_REG_HI);
   assign in_key  = (reg_addr_i >= `ADR_KEY) && (reg_addr_i <= `ADR_KEY_HI);
   // key only while key unlock enable is one
   // a zero in that bit shuts the path completely
   // background debug accesses and non-secure code cannot enter it
   assign key_ok   = opt_r[`OPT_KEY_UNLOCK_ENABLE] & secure_code_i & ~bdm_access_i;
   assign key_wr   = reg_wr_i & key_write_access_r & in_key;
   assign flash_wr = reg_wr_i & loaded_r & ~key_write_access_r & ~in_regs
                   & (reg_addr_i >= `ADR_FLASH_LO);
   assign stat_wr  = reg_wr_i & (reg_addr_i == `ADR_STAT);
   assign cmd_wr   = reg_wr_i & (reg_addr_i == `ADR_CMD);
   assign ctrl_wr  = reg_wr_i & ((reg_addr_i == `ADR_DIV) | (reg_addr_i == `ADR_CFG)
                   | (reg_addr_i == `ADR_PROT) | stat_wr | cmd_wr);

   assign cmd_legal = (reg_wdata_i == `CMD_BLANK) | (reg_wdata_i == `CMD_PROG)
                    | (reg_wdata_i == `CMD_BURST) | (reg_wdata_i == `CMD_PAGE_ERASE)
                    | (reg_wdata_i == `CMD_MASS_ERASE);
   assign is_mod    = (buf_r.code != `CMD_BLANK);

   // entered key bytes; compared once all eight are in
   always_ff @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         key_mask_r <= `ZERO8;
         for (int i = 0; i < 8; i++) begin
            key_in_r[i] <= `ZERO8;
         end
      end else if (key_mask_r == `ONES8) begin
         key_mask_r <= `ZERO8;
      end else if (key_wr && key_ok) begin
         key_in_r[reg_addr_i[2:0]]   <= reg_wdata_i;
         key_mask_r[reg_addr_i[2:0]] <= 1'b1;
      end
   end

   // full match unlocks until the next reset
   // otherwise only mass erase followed by a clean blank check
   assign unlock_set = ((key_mask_r == `ONES8) && (key_eq == `ONES8))
                     | (done_ev && buf_r.code == `CMD_BLANK && op_blank_i && mass_erased_r);

   always_ff @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         unlocked_r <= 1'b0;
      end else if (unlock_set) begin
         unlocked_r <= 1'b1;
      end
   end

   always_ff @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         mass_erased_r <= 1'b0;
      end else if (done_ev && buf_r.code == `CMD_MASS_ERASE) begin
         mass_erased_r <= 1'b1;
      end else if (start_r && is_mod) begin
         mass_erased_r <= 1'b0;
      end
   end

   // only one-zero in the security field is unsecured
   // one level gates both flash and ram access outside
   assign secure_o = ~loaded_r | ((opt_r[1:0] != `SEC_UNSECURED) & ~unlocked_r);
   assign vector_redirect_disable_o = opt_r[`OPT_NORED];

   // divider is write once; programming is refused until it is loaded
   always_ff @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         div_r <= `ZERO8;
      end else if (reg_wr_i && reg_addr_i == `ADR_DIV && !div_r[`DIV_LOADED]) begin
         div_r <= {1'b1, reg_wdata_i[6:0]};
      end
   end

   always_ff @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         key_write_access_r <= 1'b0;
      end else if (reg_wr_i && reg_addr_i == `ADR_CFG) begin
         key_write_access_r <= reg_wdata_i[`CFG_KEY_WRITE_ACCESS];
      end
   end

   assign done_ev = (seq_r == SEQ_BUSY) & op_done_i;

   // command sequencer; launch and error detection
   always_ff @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         seq_r      <= SEQ_EMPTY;
         buf_r      <= '0;
         start_r    <= 1'b0;
         pviol_set  <= 1'b0;
         accerr_set <= 1'b0;
      end else begin
         start_r    <= 1'b0;
         pviol_set  <= 1'b0;
         accerr_set <= 1'b0;
         case (seq_r)
            SEQ_EMPTY: begin
               if (flash_wr) begin
                  if (!div_r[`DIV_LOADED] || accerr_r || pviol_r) begin
                     accerr_set <= 1'b1;
                  end else begin
                     buf_r.addr <= reg_addr_i;
                     buf_r.data <= reg_wdata_i;
                     seq_r      <= SEQ_ADDR;
                  end
               end else if (cmd_wr) begin
                  accerr_set <= 1'b1;
               end
            end
            SEQ_ADDR: begin
               if (cmd_wr && cmd_legal) begin
                  buf_r.code <= reg_wdata_i;
                  seq_r      <= SEQ_CMD;
               end else if (ctrl_wr || flash_wr) begin
                  // bad code, abort or stray write ends the sequence
                  accerr_set <= 1'b1;
                  seq_r      <= SEQ_EMPTY;
               end
            end
            SEQ_CMD: begin
               if (stat_wr && reg_wdata_i[`STAT_CBEF]) begin
                  // master's one on buffer-empty registers it
                  // protected target of a modifying command becomes a violation, no launch
                  if (is_mod && prot_hit(prot_r, buf_r.addr,
                                         buf_r.code == `CMD_MASS_ERASE)) begin
                     pviol_set <= 1'b1;
                     seq_r     <= SEQ_EMPTY;
                  end else begin
                     start_r <= 1'b1;
                     seq_r   <= SEQ_BUSY;
                  end
               end else if (ctrl_wr || flash_wr) begin
                  accerr_set <= 1'b1;
                  seq_r      <= SEQ_EMPTY;
               end
            end
            SEQ_BUSY: begin
               if (flash_wr || cmd_wr) begin
                  accerr_set <= 1'b1;
               end
               if (op_done_i) begin
                  seq_r <= SEQ_EMPTY;
               end
            end
            default: begin
               seq_r <= SEQ_EMPTY;
            end
         endcase
      end
   end

   // page erase goes out page aligned, a page is 512 bytes
   always_ff @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         op_cmd_o <= '0;
      end else if (seq_r == SEQ_CMD && stat_wr && reg_wdata_i[`STAT_CBEF] && !(is_mod
                   && prot_hit(prot_r, buf_r.addr, buf_r.code == `CMD_MASS_ERASE))) begin
         op_cmd_o.code <= buf_r.code;
         op_cmd_o.data <= buf_r.data;
         op_cmd_o.addr <= (buf_r.code == `CMD_PAGE_ERASE) ? (buf_r.addr & `PAGE_MASK)
                                                          : buf_r.addr;
      end
   end

   // status flags: a set in the clearing cycle wins
   always_ff @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         pviol_r  <= 1'b0;
         accerr_r <= 1'b0;
         blank_r  <= 1'b0;
      end else begin
         pviol_r  <= pviol_set | (pviol_r & ~(stat_wr & reg_wdata_i[`STAT_PVIOL]));
         accerr_r <= accerr_set | (accerr_r & ~(stat_wr & reg_wdata_i[`STAT_ACCERR]));
         if (start_r) begin
            blank_r <= 1'b0;
         end else if (done_ev && buf_r.code == `CMD_BLANK) begin
            blank_r <= op_blank_i;
         end
      end
   end

   // interrupt status, write-one clear register, enable register
   always_ff @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         irq_stat_r <= 4'h0;
         irq_en_r   <= 4'h0;
      end else begin
         irq_stat_r[`IRQ_DONE]   <= done_ev | (irq_stat_r[`IRQ_DONE]
                                 & ~(reg_wr_i && reg_addr_i == `ADR_IRQ_CLR && reg_wdata_i[0]));
         irq_stat_r[`IRQ_PVIOL]  <= pviol_set | (irq_stat_r[`IRQ_PVIOL]
                                 & ~(reg_wr_i && reg_addr_i == `ADR_IRQ_CLR && reg_wdata_i[1]));
         irq_stat_r[`IRQ_ACCERR] <= accerr_set | (irq_stat_r[`IRQ_ACCERR]
                                 & ~(reg_wr_i && reg_addr_i == `ADR_IRQ_CLR && reg_wdata_i[2]));
         irq_stat_r[`IRQ_UNSEC]  <= unlock_set | (irq_stat_r[`IRQ_UNSEC]
                                 & ~(reg_wr_i && reg_addr_i == `ADR_IRQ_CLR && reg_wdata_i[3]));
         if (reg_wr_i && reg_addr_i == `ADR_IRQ_EN) begin
            irq_en_r <= reg_wdata_i[3:0];
         end
      end
   end

   assign stat_view = {(seq_r != SEQ_BUSY) && (seq_r == SEQ_EMPTY), seq_r != SEQ_BUSY,
                       pviol_r, accerr_r, 1'b0, blank_r, 2'h0};
   assign opt_view  = {opt_r[7:6], 4'h0, opt_r[1:0]};

   // read data valid only in the cycle after the strobe; unmapped reads zero
   always_ff @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         rdata_r <= `ZERO8;
      end else if (!reg_rd_i) begin
         rdata_r <= `ZERO8;
      end else if (reg_addr_i == `ADR_DIV) begin
         rdata_r <= div_r;
      end else if (reg_addr_i == `ADR_OPT) begin
         rdata_r <= opt_view;
      end else if (reg_addr_i == `ADR_CFG) begin
         rdata_r <= {2'h0, key_write_access_r, 5'h00};
      end else if (reg_addr_i == `ADR_PROT) begin
         rdata_r <= prot_r;
      end else if (reg_addr_i == `ADR_STAT) begin
         rdata_r <= stat_view;
      end else if (reg_addr_i == `ADR_CMD) begin
         rdata_r <= buf_r.code;
      end else if (reg_addr_i == `ADR_IRQ_STAT) begin
         rdata_r <= {4'h0, irq_stat_r};
      end else if (reg_addr_i == `ADR_IRQ_EN) begin
         rdata_r <= {4'h0, irq_en_r};
      end else begin
         rdata_r <= `ZERO8;
      end
   end

   assign reg_rdata_o = rdata_r;
   assign nv_addr_o   = nv_addr_r;
   assign load_done_o = loaded_r;
   assign op_start_o  = start_r;
   // level interrupt from registered status and enable only
   assign irq_o       = |(irq_stat_r & irq_en_r);

endmodule

// *** verif/flash_nv_model.sv ***
// far side model: nonvolatile setup bytes, key bytes and the program/erase engine
// assumes the controller's registered load address and one-cycle launch pulse
`include "flash_sec_consts.svh"
module flash_nv_model
   import flash_sec_pkg::*;
#(
   parameter int DLY = 5
)
(
   input  wire logic        core_clk_i,
   input  wire logic        arst_n_i,
   input  wire logic [7:0]  nv_prot_i,
   input  wire logic [7:0]  nv_opt_i,
   input  wire logic [63:0] key_i,
   input  wire logic [15:0] nv_addr_i,
   output      logic [7:0]  nv_data_o,
   input  wire logic        op_start_i,
   input  wire flash_cmd_t  op_cmd_i,
   output      logic        op_done_o,
   output      logic        op_blank_o
);
   int   cnt;
   logic blank_r = 1'b0;
   // setup bytes and key answered one cycle after the address
   always_ff @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) nv_data_o <= 8'h00;
      else if (nv_addr_i == `ADR_NV_PROTECTION_SETUP) nv_data_o <= nv_prot_i;
      else if (nv_addr_i == `ADR_NV_OPTION_SETUP) nv_data_o <= nv_opt_i;
      else if (nv_addr_i >= `ADR_KEY && nv_addr_i <= `ADR_KEY_HI)
         nv_data_o <= key_i[8*nv_addr_i[2:0] +: 8];
      else nv_data_o <= ~nv_data_o;
   end
   // operations finish on their own; blank only after mass erase
   always_ff @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         cnt <= 0;
         op_done_o <= 1'b0;
         op_blank_o <= 1'b0;
      end else begin
         op_done_o <= 1'b0;
         // toggles so a result read outside the done cycle is never trusted
         op_blank_o <= ~op_blank_o;
         if (op_start_i) cnt <= DLY;
         else if (cnt == 1) begin
            cnt <= 0;
            op_done_o <= 1'b1;
            op_blank_o <= blank_r;
            if (op_cmd_i.code == `CMD_MASS_ERASE) blank_r <= 1'b1;
            else if (op_cmd_i.code != `CMD_BLANK) blank_r <= 1'b0;
         end else if (cnt > 1) cnt <= cnt - 1;
      end
   end
endmodule

// *** verif/flash_sec_ctrl_props.sv ***
// port checker for the flash security front end
// assumes one clock domain and binding onto flash_sec_ctrl
`include "flash_sec_consts.svh"
module flash_sec_ctrl_props
   import flash_sec_pkg::*;
(
   input wire logic        core_clk_i,
   input wire logic        arst_n_i,
   input wire logic [15:0] reg_addr_i,
   input wire logic [7:0]  reg_wdata_i,
   input wire logic        reg_wr_i,
   input wire logic        reg_rd_i,
   input wire logic [7:0]  reg_rdata_o,
   input wire logic [15:0] nv_addr_o,
   input wire logic [7:0]  nv_data_i,
   input wire logic        load_done_o,
   input wire logic        op_start_o,
   input wire flash_cmd_t  op_cmd_o,
   input wire logic        secure_o,
   input wire logic        vector_redirect_disable_o
);
   logic       opt_at_r;
   logic [7:0] opt_r;
   logic [3:0] ld_cnt_r;
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (!arst_n_i);
   always_ff @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         opt_at_r <= 1'b0;
         ld_cnt_r <= 4'h0;
      end else begin
         opt_at_r <= !load_done_o && nv_addr_o == `ADR_NV_OPTION_SETUP;
         if (!load_done_o && ld_cnt_r != 4'hF) ld_cnt_r <= ld_cnt_r + 4'h1;
      end
   end
   // option byte as the array delivered it, independent of the copy register
   always_ff @(posedge core_clk_i) begin
      if (opt_at_r) opt_r <= nv_data_i;
   end
   sequence s_load_head;
      nv_addr_o == `ADR_NV_PROTECTION_SETUP ##1 nv_addr_o == `ADR_NV_OPTION_SETUP;
   endsequence
   a_load_order: assert property (
      !load_done_o && nv_addr_o == `ADR_NV_PROTECTION_SETUP |-> s_load_head ##1 nv_addr_o == `ADR_KEY)
      else $error("setup load order broken");
   a_load_bound: assert property (!load_done_o |-> ld_cnt_r < 4'hB)
      else $error("load took too long");
   a_opt_read: assert property (
      $past(reg_rd_i) && $past(reg_addr_i) == `ADR_OPT && load_done_o |-> reg_rdata_o == opt_r)
      else $error("option copy differs from setup byte");
   a_redirect_copy: assert property (
      load_done_o && $past(load_done_o) |-> vector_redirect_disable_o == opt_r[`OPT_NORED])
      else $error("redirect output differs from option");
   a_secure_preload: assert property (!load_done_o |-> secure_o)
      else $error("unsecured before load");
   a_sec_eval: assert property (
      $rose(load_done_o) |=> secure_o == (opt_r[1:0] != `SEC_UNSECURED))
      else $error("security state wrong after load");
   a_rdata_idle: assert property (!$past(reg_rd_i) |-> reg_rdata_o == `ZERO8)
      else $error("read data outside read cycle");
   a_launch_cause: assert property (
      op_start_o |-> $past(reg_wr_i) && $past(reg_addr_i) == `ADR_STAT
                     && $past(reg_wdata_i) >= 8'h80)
      else $error("launch without buffer-empty write");
   a_legal_code: assert property (
      op_start_o |-> op_cmd_o.code inside {`CMD_BLANK, `CMD_PROG, `CMD_BURST,
                                           `CMD_PAGE_ERASE, `CMD_MASS_ERASE})
      else $error("illegal command launched");
   a_cmd_hold: assert property (!op_start_o |-> $stable(op_cmd_o))
      else $error("command changed without launch");
   a_page_align: assert property (
      op_start_o && op_cmd_o.code == `CMD_PAGE_ERASE |-> op_cmd_o.addr[8:0] == 9'h000)
      else $error("page erase address not aligned");
endmodule
bind flash_sec_ctrl flash_sec_ctrl_props props (.core_clk_i, .arst_n_i, .reg_addr_i,
   .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o, .nv_addr_o, .nv_data_i, .load_done_o,
   .op_start_o, .op_cmd_o, .secure_o, .vector_redirect_disable_o);

// *** verif/tb_top.sv ***
// self-checking bench for the flash security, protection and command front end
// assumes the array model answers the reset load and every launch
`include "flash_sec_consts.svh"
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   import flash_sec_pkg::*;
   logic        clk = 1'b0;
   logic        rst_n = 1'b0;
   logic [15:0] addr = 16'h0000;
   logic [7:0]  wdata = 8'h00;
   logic        wr = 1'b0;
   logic        rd = 1'b0;
   logic        bdm = 1'b0;
   logic        scode = 1'b0;
   logic [7:0]  nvp = 8'hC0;
   logic [7:0]  nvo = 8'h42;
   logic [63:0] key = 64'h0123_4567_89AB_CDEF;
   logic [7:0]  rdata, nvd, got;
   logic [15:0] nva;
   logic        ld, start, done, blank, sec, nored, irq;
   flash_cmd_t  cmd;
   logic [7:0]  codes [5] = '{8'h20, 8'h25, 8'h40, 8'h41, 8'h05};
   int          err_total = 0;
   int          cmp_count = 0;
   always #50 clk = ~clk;
   flash_sec_ctrl dut (.core_clk_i(clk), .arst_n_i(rst_n), .reg_addr_i(addr),
      .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata),
      .bdm_access_i(bdm), .secure_code_i(scode), .nv_addr_o(nva), .nv_data_i(nvd),
      .load_done_o(ld), .op_start_o(start), .op_cmd_o(cmd), .op_done_i(done),
      .op_blank_i(blank), .secure_o(sec), .vector_redirect_disable_o(nored), .irq_o(irq));
   flash_nv_model nvm (.core_clk_i(clk), .arst_n_i(rst_n), .nv_prot_i(nvp), .nv_opt_i(nvo),
      .key_i(key), .nv_addr_i(nva), .nv_data_o(nvd), .op_start_i(start), .op_cmd_i(cmd),
      .op_done_o(done), .op_blank_o(blank));
   task automatic chk(input logic [15:0] g, input logic [15:0] e);
      cmp_count++;
      if (g !== e) begin
         err_total++;
         $display("wrong value at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   task automatic wr_reg(input logic [15:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
      #1;
   endtask
   task automatic rdc(input logic [15:0] a, input logic [7:0] m, input logic [7:0] e);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      got = rdata;
      chk(got & m, e);
   endtask
   task automatic boot(input logic [7:0] p, input logic [7:0] o);
      @(posedge clk);
      rst_n <= 1'b0;
      nvp <= p;
      nvo <= o;
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
      repeat (13) @(posedge clk);
      wr_reg(`ADR_DIV, 8'h13);
   endtask
   // flash write, command, launch; a refused launch must set the violation flag, which is then cleared
   task automatic run(input logic [15:0] a, input logic [7:0] c, input logic go);
      int n;
      wr_reg(a, 8'h55);
      wr_reg(`ADR_CMD, c);
      wr_reg(`ADR_STAT, 8'h80);
      @(negedge clk);
      chk({15'h0, start}, {15'h0, go});
      if (start === 1'b1) begin
         chk(cmd.code, c);
         chk(cmd.data, 8'h55);
         chk(cmd.addr, c == `CMD_PAGE_ERASE ? a & `PAGE_MASK : a);
         n = 0;
         while (done !== 1'b1 && n < 50) begin
            @(negedge clk);
            n++;
         end
         chk({15'h0, done}, 16'h0001);
         rdc(`ADR_STAT, 8'hC0, 8'hC0);
      end else begin
         rdc(`ADR_STAT, 8'h20, 8'h20);
         wr_reg(`ADR_STAT, 8'h20);
      end
   endtask
   task automatic key_in(input logic b, input logic [63:0] k);
      @(posedge clk);
      scode <= 1'b1;
      bdm <= b;
      wr_reg(`ADR_CFG, 8'h20);
      for (int i = 0; i < 8; i++) wr_reg(16'(`ADR_KEY + i), k[8*i +: 8]);
      repeat (3) @(posedge clk);
      bdm <= 1'b0;
   endtask
   task automatic test_done();
      $display("comparisons %0d, mismatches %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   initial begin
      boot(8'hC0, 8'h42);
      rdc(`ADR_OPT, 8'hFF, 8'h42);
      rdc(`ADR_PROT, 8'hFF, 8'hC0);
      chk({14'h0, sec, nored}, 16'h0001);
      rdc(`ADR_DIV, 8'hFF, 8'h93);
      wr_reg(`ADR_DIV, 8'h05);
      rdc(`ADR_DIV, 8'hFF, 8'h93);
      rdc(16'h1822, 8'hFF, 8'h00);
      $display("test load done");
      foreach (codes[i]) run(16'hF123, codes[i], 1'b1);
      rdc(`ADR_STAT, 8'h04, 8'h04);
      rdc(`ADR_IRQ_STAT, 8'h01, 8'h01);
      chk({15'h0, irq}, 16'h0000);
      wr_reg(`ADR_IRQ_EN, 8'h01);
      chk({15'h0, irq}, 16'h0001);
      wr_reg(`ADR_IRQ_CLR, 8'h01);
      chk({15'h0, irq}, 16'h0000);
      rdc(`ADR_IRQ_STAT, 8'h01, 8'h00);
      wr_reg(16'hF000, 8'h55);
      wr_reg(`ADR_CMD, 8'h30);
      rdc(`ADR_STAT, 8'h10, 8'h10);
      wr_reg(`ADR_STAT, 8'h10);
      rdc(`ADR_STAT, 8'h10, 8'h00);
      $display("test commands done");
      for (int s = 0; s < 7; s++) begin
         wr_reg(`ADR_PROT, {2'b10, s[2:0], 3'b000});
         run(16'hFFFF - (16'h0200 << s) + 16'h0001, `CMD_PROG, 1'b0);
         run(16'hFFFF - (16'h0200 << s), `CMD_PROG, 1'b1);
      end
      wr_reg(`ADR_PROT, 8'h00);
      run(16'h2000, `CMD_PROG, 1'b0);
      run(16'h2000, `CMD_MASS_ERASE, 1'b0);
      $display("test protection done");
      boot(8'hC0, 8'h80);
      chk({15'h0, sec}, 16'h0001);
      key_in(1'b1, key);
      chk({15'h0, sec}, 16'h0001);
      key_in(1'b0, key ^ 64'h0000_0000_0000_0100);
      chk({15'h0, sec}, 16'h0001);
      boot(8'hC0, 8'h80);
      key_in(1'b0, key);
      chk({15'h0, sec}, 16'h0000);
      rdc(`ADR_IRQ_STAT, 8'h08, 8'h08);
      $display("test key done");
      boot(8'hC0, 8'h00);
      key_in(1'b0, key);
      chk({15'h0, sec}, 16'h0001);
      scode <= 1'b0;
      wr_reg(`ADR_CFG, 8'h00);
      run(16'h2000, `CMD_MASS_ERASE, 1'b1);
      chk({15'h0, sec}, 16'h0001);
      run(16'h2000, `CMD_BLANK, 1'b1);
      chk({15'h0, sec}, 16'h0000);
      $display("test erase unlock done");
      test_done();
   end
   // the whole sequence needs under 2000 cycles
   initial begin
      repeat (5000) @(posedge clk);
      err_total++;
      test_done();
   end
endmodule
